// [design/swd_defs.svh]
// Purpose: named constants of the software watchdog
// Assumes: 40 MHz aclk, AXI4-Lite register access
// Notes:   offsets are byte addresses of aligned 32-bit words
`ifndef SWD_DEFS_SVH
`define SWD_DEFS_SVH

// ****************************************
// bus and register map
// ****************************************
`define SWD_ADDR_W       8
`define SWD_DATA_W       32
`define SWD_OFF_OPT      8'h00
`define SWD_OFF_OPT2     8'h04
`define SWD_OFF_RSTAT    8'h08
`define SWD_OFF_ISTAT    8'h0C
`define SWD_OFF_IMASK    8'h10
`define SWD_OFF_COUNT    8'h14
`define SWD_RESP_OKAY    2'h0
`define SWD_RESP_SLVERR  2'h2

// ****************************************
// field positions and reset values
// ****************************************
`define SWD_BIT_EN       0
`define SWD_BIT_TSEL     1
`define SWD_BIT_CSEL     0
`define SWD_BIT_RS_WDOG  5
`define SWD_BIT_RS_POR   7
`define SWD_IRQ_OVF      0
`define SWD_IRQ_SVC      1
`define SWD_IRQ_W        2
`define SWD_RST_EN       1'h1
`define SWD_RST_TSEL     1'h1
`define SWD_RST_CSEL     1'h1

// ****************************************
// counter and timing
// ****************************************
`define SWD_CNT_W        19
`define SWD_LIM_KHZ_SH   19'h00020
`define SWD_LIM_KHZ_LG   19'h00100
`define SWD_LIM_BUS_SH   19'h02000
`define SWD_LIM_BUS_LG   19'h40000
`define SWD_CLK_HZ       40000000
`define SWD_TICK_HZ      1000
`define SWD_TICK_W       16

`endif

// [design/swd_pkg.sv]
// Purpose: state types of the software watchdog
// Assumes: swd_defs.svh supplies the widths
// Notes:   one packed struct per module
`include "swd_defs.svh"

package swd_pkg;

   // ****************************************
   // register, bus, counter and tick state
   // ****************************************
   typedef struct packed {
      logic                     aw_held;
      logic [`SWD_ADDR_W-1:0]   aw_addr;
      logic                     w_held;
      logic [`SWD_DATA_W-1:0]   w_data;
      logic                     w_strb0;
      logic                     bvalid;
      logic [1:0]               bresp;
      logic                     rvalid;
      logic [`SWD_DATA_W-1:0]   rdata;
      logic [1:0]               rresp;
      logic                     opt_en;
      logic                     opt_tsel;
      logic                     opt_lock;
      logic                     opt_csel;
      logic                     opt2_lock;
      logic                     rs_wdog;
      logic                     rs_por;
      logic [`SWD_IRQ_W-1:0]    int_st;
      logic [`SWD_IRQ_W-1:0]    int_mask;
      logic                     sys_reset_req;
      logic                     irq;
   } swd_main_t;

   typedef struct packed {
      logic [`SWD_CNT_W-1:0]    count;
   } swd_cnt_t;

   typedef struct packed {
      logic [`SWD_TICK_W-1:0]   div;
      logic                     tick;
   } swd_tick_t;

endpackage

// [design/swd_tick.sv]
// Purpose: internal 1 kHz tick from the bus clock
// Assumes: aclk at 40 MHz
// Notes:   TICK_DIV may be shortened in simulation
`timescale 1ns/1ps
`include "swd_defs.svh"

module swd_tick
   import swd_pkg::*;
#(
   parameter int TICK_DIV = `SWD_CLK_HZ / `SWD_TICK_HZ
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   output logic      tick
);

   swd_tick_t st;
   swd_tick_t next_st;

   // ****************************************
   // free running divider
   // ****************************************
   always_comb begin
      next_st      = st;
      next_st.tick = 1'b0;
      if (st.div == `SWD_TICK_W'(TICK_DIV - 1)) begin
         next_st.div  = '0;
         next_st.tick = 1'b1;
      end else begin
         next_st.div = st.div + `SWD_TICK_W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick = st.tick;

endmodule // swd_tick

// [design/swd_counter.sv]
// Purpose: watchdog counter with selectable clock and overflow
// Assumes: tick_1khz is a one-cycle pulse
// Notes:   overflow is combinational, one cycle per timeout
`timescale 1ns/1ps
`include "swd_defs.svh"

module swd_counter
   import swd_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  enable,
   input  wire logic                  restart,
   input  wire logic                  debug_mode,
   input  wire logic                  stop_mode,
   input  wire logic                  clk_sel,
   input  wire logic                  tout_sel,
   input  wire logic                  tick_1khz,
   output logic [`SWD_CNT_W-1:0]      count,
   output logic                       overflow
);

   swd_cnt_t st;
   swd_cnt_t next_st;
   logic     inc;
   logic     clr;

   function automatic logic [`SWD_CNT_W-1:0] ovf_limit(input logic csel, input logic tsel);
      if (csel) begin
         ovf_limit = tsel ? `SWD_LIM_BUS_LG : `SWD_LIM_BUS_SH;
      end else begin
         ovf_limit = tsel ? `SWD_LIM_KHZ_LG : `SWD_LIM_KHZ_SH;
      end
   endfunction

   // ****************************************
   // count control
   // ****************************************
   always_comb begin
      clr      = !enable || (!clk_sel && stop_mode);
      inc      = !debug_mode && !stop_mode && (clk_sel || tick_1khz);
      overflow = enable && !clr && inc && !restart
                 && (st.count == ovf_limit(clk_sel, tout_sel) - `SWD_CNT_W'(1));
      next_st  = st;
      if (restart || clr || overflow) begin
         next_st.count = '0;
      end else if (inc) begin
         next_st.count = st.count + `SWD_CNT_W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign count = st.count;

   a_debug_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (debug_mode && !restart && !clr) |=> $stable(count)) else $error("count moved in debug");
   a_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (stop_mode && clk_sel && enable && !restart) |=> $stable(count)) else $error("count moved in stop");
   a_stop_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      (stop_mode && !clk_sel) |=> (count == '0)) else $error("count not cleared in stop");
   a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
      (inc && !clr && !restart && !overflow) |=> (count == $past(count) + `SWD_CNT_W'(1)))
      else $error("count did not step");

endmodule // swd_counter

// [design/swd_watchdog.sv]
// Purpose: software watchdog with AXI4-Lite registers
// Assumes: aclk 40 MHz, synchronous active low aresetn
// Notes:   overflow acts as an internal reset of the options
`timescale 1ns/1ps
`include "swd_defs.svh"

module swd_watchdog
   import swd_pkg::*;
#(
   parameter int TICK_DIV = `SWD_CLK_HZ / `SWD_TICK_HZ
) (
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic [`SWD_ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [`SWD_DATA_W-1:0]   s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [`SWD_ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [`SWD_DATA_W-1:0]        s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   input  wire logic                     debug_mode,
   input  wire logic                     stop_mode,
   output logic                          sys_reset_req,
   output logic                          irq
);

   swd_main_t                st;
   swd_main_t                next_st;
   logic                     wr_go;
   logic                     rd_go;
   logic                     restart;
   logic                     ovf;
   logic                     tick_1khz;
   logic [`SWD_CNT_W-1:0]    count;
   logic [`SWD_IRQ_W-1:0]    events;

   // ****************************************
   // address decode
   // ****************************************
   function automatic logic is_mapped(input logic [`SWD_ADDR_W-1:0] a);
      is_mapped = (a == `SWD_OFF_OPT)   || (a == `SWD_OFF_OPT2)
               || (a == `SWD_OFF_RSTAT) || (a == `SWD_OFF_ISTAT)
               || (a == `SWD_OFF_IMASK) || (a == `SWD_OFF_COUNT);
   endfunction

   function automatic logic [`SWD_DATA_W-1:0] read_word(input logic [`SWD_ADDR_W-1:0] a,
                                                        input swd_main_t s,
                                                        input logic [`SWD_CNT_W-1:0] c);
      read_word = '0;
      unique case (a)
         `SWD_OFF_OPT: begin
            read_word[`SWD_BIT_EN]   = s.opt_en;
            read_word[`SWD_BIT_TSEL] = s.opt_tsel;
         end
         `SWD_OFF_OPT2: begin
            read_word[`SWD_BIT_CSEL] = s.opt_csel;
         end
         `SWD_OFF_RSTAT: begin
            read_word[`SWD_BIT_RS_WDOG] = s.rs_wdog;
            read_word[`SWD_BIT_RS_POR]  = s.rs_por;
         end
         `SWD_OFF_ISTAT: begin
            read_word[`SWD_IRQ_W-1:0] = s.int_st;
         end
         `SWD_OFF_IMASK: begin
            read_word[`SWD_IRQ_W-1:0] = s.int_mask;
         end
         `SWD_OFF_COUNT: begin
            read_word[`SWD_CNT_W-1:0] = c;
         end
         default: begin
            read_word = '0;
         end
      endcase
   endfunction

   // ****************************************
   // tick source and counter
   // ****************************************
   swd_tick #(
      .TICK_DIV (TICK_DIV)
   ) u_tick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick_1khz)
   );

   swd_counter u_counter (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .enable     (st.opt_en),
      .restart    (restart),
      .debug_mode (debug_mode),
      .stop_mode  (stop_mode),
      .clk_sel    (st.opt_csel),
      .tout_sel   (st.opt_tsel),
      .tick_1khz  (tick_1khz),
      .count      (count),
      .overflow   (ovf)
   );

   // ****************************************
   // bus handshakes
   // ****************************************
   assign s_axi_awready = !st.aw_held && !st.bvalid;
   assign s_axi_wready  = !st.w_held && !st.bvalid;
   assign s_axi_arready = !st.rvalid;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;
   assign sys_reset_req = st.sys_reset_req;
   assign irq           = st.irq;

   assign wr_go   = st.aw_held && st.w_held;
   assign rd_go   = s_axi_arvalid && !st.rvalid;
   assign restart = wr_go && ((st.aw_addr == `SWD_OFF_RSTAT)
                           || (st.aw_addr == `SWD_OFF_OPT && !st.opt_lock)
                           || (st.aw_addr == `SWD_OFF_OPT2 && !st.opt2_lock));

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_st = st;
      next_st.sys_reset_req = 1'b0;
      events = '0;
      events[`SWD_IRQ_OVF] = ovf;
      events[`SWD_IRQ_SVC] = wr_go && (st.aw_addr == `SWD_OFF_RSTAT);

      // write address and data, either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_held  = 1'b1;
         next_st.w_data  = s_axi_wdata;
         next_st.w_strb0 = s_axi_wstrb[0];
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end

      if (wr_go) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = is_mapped(st.aw_addr) ? `SWD_RESP_OKAY : `SWD_RESP_SLVERR;
         if (st.aw_addr == `SWD_OFF_OPT && !st.opt_lock) begin
            next_st.opt_lock = 1'b1;
            if (st.w_strb0) begin
               next_st.opt_en   = st.w_data[`SWD_BIT_EN];
               next_st.opt_tsel = st.w_data[`SWD_BIT_TSEL];
            end
         end
         if (st.aw_addr == `SWD_OFF_OPT2 && !st.opt2_lock) begin
            next_st.opt2_lock = 1'b1;
            if (st.w_strb0) begin
               next_st.opt_csel = st.w_data[`SWD_BIT_CSEL];
            end
         end
         if (st.aw_addr == `SWD_OFF_IMASK && st.w_strb0) begin
            next_st.int_mask = st.w_data[`SWD_IRQ_W-1:0];
         end
      end

      // read channel, interrupt status cleared by its read
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (rd_go) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = read_word(s_axi_araddr, st, count);
         next_st.rresp  = is_mapped(s_axi_araddr) ? `SWD_RESP_OKAY : `SWD_RESP_SLVERR;
         if (s_axi_araddr == `SWD_OFF_ISTAT) begin
            next_st.int_st = '0;
         end
      end
      next_st.int_st = next_st.int_st | events;

      // watchdog timeout acts as a reset of the options
      if (ovf) begin
         next_st.sys_reset_req = 1'b1;
         next_st.rs_wdog   = 1'b1;
         next_st.rs_por    = 1'b0;
         next_st.opt_en    = `SWD_RST_EN;
         next_st.opt_tsel  = `SWD_RST_TSEL;
         next_st.opt_csel  = `SWD_RST_CSEL;
         next_st.opt_lock  = 1'b0;
         next_st.opt2_lock = 1'b0;
      end
      next_st.irq = |(next_st.int_st & next_st.int_mask);
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st          <= '0;
         st.opt_en   <= `SWD_RST_EN;
         st.opt_tsel <= `SWD_RST_TSEL;
         st.opt_csel <= `SWD_RST_CSEL;
         st.rs_por   <= 1'b1;
         st.bresp    <= `SWD_RESP_OKAY;
         st.rresp    <= `SWD_RESP_OKAY;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_reset_enable: assert property (@(posedge aclk) disable iff (!aresetn)
      (st.sys_reset_req || $rose(aresetn)) |-> st.opt_en) else $error("enable not set after reset");
   a_disabled_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      (!st.opt_en) |=> !st.sys_reset_req) else $error("timeout while disabled");
   a_service_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      restart |=> (count == '0)) else $error("service did not zero counter");
   a_status_kept: assert property (@(posedge aclk) disable iff (!aresetn)
      (restart && !ovf) |=> ($stable(st.rs_wdog) && $stable(st.rs_por))) else $error("status changed by service");
   a_default_cfg: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> (st.opt_csel && st.opt_tsel)) else $error("wrong default config");
   a_timeout_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      ovf |=> (st.sys_reset_req ##1 !st.sys_reset_req)) else $error("no reset pulse on timeout");
   a_lock_write: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_go && st.opt_lock && st.aw_addr == `SWD_OFF_OPT && !ovf)
      |=> ($stable(st.opt_en) && $stable(st.opt_tsel))) else $error("locked option changed");
   a_first_restart: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_go && st.aw_addr == `SWD_OFF_OPT2 && !st.opt2_lock) |=> (count == '0 && st.opt2_lock))
      else $error("first option write did not restart");
   a_wdog_status: assert property (@(posedge aclk) disable iff (!aresetn)
      ovf |=> (st.rs_wdog && !st.rs_por)) else $error("watchdog reset not recorded");

   // ****************************************
   // counter, option and status checks
   // ****************************************
   a_opt_first: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_go && st.aw_addr == `SWD_OFF_OPT && !st.opt_lock) |=> (count == '0 && st.opt_lock))
      else $error("first enable write did not restart");
   a_opt2_locked: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_go && st.opt2_lock && st.aw_addr == `SWD_OFF_OPT2 && !ovf) |=> $stable(st.opt_csel))
      else $error("locked clock select changed");
   a_ovf_enabled: assert property (@(posedge aclk) disable iff (!aresetn)
      ovf |-> st.opt_en)
      else $error("overflow while disabled");
   a_count_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      (!st.opt_en) |=> (count == '0))
      else $error("counter moved while disabled");
   a_debug_no_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
      debug_mode |-> !ovf)
      else $error("overflow in debug");
   a_stop_no_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
      stop_mode |-> !ovf)
      else $error("overflow in stop");
   a_bus_limit: assert property (@(posedge aclk) disable iff (!aresetn)
      (ovf && st.opt_csel)
      |-> (count == ((st.opt_tsel ? `SWD_LIM_BUS_LG : `SWD_LIM_BUS_SH) - `SWD_CNT_W'(1))))
      else $error("bus clock overflow at wrong count");
   a_khz_limit: assert property (@(posedge aclk) disable iff (!aresetn)
      (ovf && !st.opt_csel)
      |-> (count == ((st.opt_tsel ? `SWD_LIM_KHZ_LG : `SWD_LIM_KHZ_SH) - `SWD_CNT_W'(1))))
      else $error("tick clock overflow at wrong count");
   a_khz_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (!st.opt_csel && st.opt_en && !stop_mode && !tick_1khz && !restart) |=> $stable(count))
      else $error("count moved without tick");
   a_bus_step: assert property (@(posedge aclk) disable iff (!aresetn)
      (st.opt_csel && st.opt_en && !stop_mode && !debug_mode && !restart && !ovf)
      |=> (count == $past(count) + `SWD_CNT_W'(1))) else $error("count missed a bus cycle");
   a_reset_defaults: assert property (@(posedge aclk) disable iff (!aresetn)
      st.sys_reset_req |-> (st.opt_csel && st.opt_tsel && !st.opt_lock && !st.opt2_lock))
      else $error("options not restored by timeout");
   a_por_status: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> (st.rs_por && !st.rs_wdog))
      else $error("wrong reset status after reset");
   a_svc_event: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_go && st.aw_addr == `SWD_OFF_RSTAT) |=> st.int_st[`SWD_IRQ_SVC])
      else $error("service event not recorded");

endmodule // swd_watchdog

// [tb/tb_top.sv]
// Purpose: self-checking bench for the software watchdog
// Assumes: AXI4-Lite master driven here, TICK_DIV shortened to 4
// Notes:   long default timeout of 2^18 is checked by reset values only
`timescale 1ns/1ps
`include "swd_defs.svh"

module tb_top
   import swd_pkg::*;
;
   localparam int TDIV = 4;
   logic                   aclk;
   logic                   aresetn;
   logic [`SWD_ADDR_W-1:0] s_axi_awaddr;
   logic                   s_axi_awvalid;
   logic                   s_axi_awready;
   logic [`SWD_DATA_W-1:0] s_axi_wdata;
   logic [3:0]             s_axi_wstrb;
   logic                   s_axi_wvalid;
   logic                   s_axi_wready;
   logic [1:0]             s_axi_bresp;
   logic                   s_axi_bvalid;
   logic                   s_axi_bready;
   logic [`SWD_ADDR_W-1:0] s_axi_araddr;
   logic                   s_axi_arvalid;
   logic                   s_axi_arready;
   logic [`SWD_DATA_W-1:0] s_axi_rdata;
   logic [1:0]             s_axi_rresp;
   logic                   s_axi_rvalid;
   logic                   s_axi_rready;
   logic                   debug_mode;
   logic                   stop_mode;
   logic                   sys_reset_req;
   logic                   irq;
   logic [31:0]            rv;
   logic [31:0]            rv2;
   logic [1:0]             resp;
   int                     fails;
   int                     compares;
   int                     n;

   // ****************************************
   // clock, device
   // ****************************************
   always #12.5 aclk = ~aclk;

   swd_watchdog #(.TICK_DIV(TDIV)) uut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .debug_mode, .stop_mode, .sys_reset_req, .irq
   );

   // ****************************************
   // checking and closing
   // ****************************************
   task automatic summarize();
      if (fails == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic hang();
      fails++;
      summarize();
   endtask

   // ****************************************
   // bus cycles
   // ****************************************
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!(s_axi_bvalid && s_axi_bready) && k < 200);
      if (k >= 200) hang();
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      int k;
      k = 0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(s_axi_rvalid && s_axi_rready) && k < 200);
      if (k >= 200) hang();
      d = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   // cycles until a reset pulse, lim if none
   task automatic wait_rst(input int lim);
      n = 0;
      while (n < lim && sys_reset_req !== 1'b1) begin
         @(posedge aclk);
         n++;
      end
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic run_defaults();
      axi_rd(`SWD_OFF_OPT, rv);
      check(rv, 32'h00000003);
      check(resp, `SWD_RESP_OKAY);
      axi_rd(`SWD_OFF_OPT2, rv);
      check(rv, 32'h00000001);
      axi_rd(`SWD_OFF_RSTAT, rv);
      check(rv, 32'h00000080);
      axi_rd(8'h20, rv);
      check(rv, 32'h00000000);
      check(resp, `SWD_RESP_SLVERR);
      axi_wr(8'h24, 32'h0);
      check(resp, `SWD_RESP_SLVERR);
      debug_mode <= 1'b1;
      axi_rd(`SWD_OFF_COUNT, rv);
      repeat (20) @(posedge aclk);
      axi_rd(`SWD_OFF_COUNT, rv2);
      check(rv2, rv);
      debug_mode <= 1'b0;
      stop_mode <= 1'b1;
      axi_rd(`SWD_OFF_COUNT, rv);
      repeat (20) @(posedge aclk);
      axi_rd(`SWD_OFF_COUNT, rv2);
      check(rv2, rv);
      stop_mode <= 1'b0;
      repeat (10) @(posedge aclk);
      axi_rd(`SWD_OFF_COUNT, rv);
      check(rv > rv2, 1);
      axi_wr(`SWD_OFF_RSTAT, 32'hFFFFFFFF);
      axi_rd(`SWD_OFF_COUNT, rv);
      check(rv < 8, 1);
      axi_rd(`SWD_OFF_RSTAT, rv);
      check(rv, 32'h00000080);
      axi_rd(`SWD_OFF_ISTAT, rv);
      check(rv, 32'h00000002);
      axi_rd(`SWD_OFF_ISTAT, rv);
      check(rv, 32'h00000000);
   endtask

   task automatic run_lock_timeout();
      axi_wr(`SWD_OFF_IMASK, 32'h00000001);
      check(resp, `SWD_RESP_OKAY);
      axi_wr(`SWD_OFF_OPT, 32'h00000001);
      axi_rd(`SWD_OFF_COUNT, rv);
      check(rv < 8, 1);
      axi_wr(`SWD_OFF_OPT, 32'h00000002);
      axi_rd(`SWD_OFF_OPT, rv);
      check(rv, 32'h00000001);
      axi_wr(`SWD_OFF_OPT2, 32'h00000001);
      check(irq, 1'b0);
      wait_rst(9000);
      check(n > 7900 && n < 8200, 1);
      repeat (3) @(posedge aclk);
      check(irq, 1'b1);
      axi_rd(`SWD_OFF_RSTAT, rv);
      check(rv, 32'h00000020);
      axi_rd(`SWD_OFF_OPT, rv);
      check(rv, 32'h00000003);
      axi_rd(`SWD_OFF_ISTAT, rv);
      check(rv, 32'h00000001);
      repeat (3) @(posedge aclk);
      check(irq, 1'b0);
   endtask

   task automatic run_khz();
      axi_wr(`SWD_OFF_OPT2, 32'h00000000);
      axi_wr(`SWD_OFF_OPT, 32'h00000001);
      repeat (60) @(posedge aclk);
      stop_mode <= 1'b1;
      repeat (10) @(posedge aclk);
      axi_rd(`SWD_OFF_COUNT, rv);
      check(rv, 32'h0);
      stop_mode <= 1'b0;
      wait_rst(400);
      check(n >= 32 * TDIV - 8 && n <= 32 * TDIV + 8, 1);
      repeat (3) @(posedge aclk);
      axi_rd(`SWD_OFF_ISTAT, rv);
      check(rv, 32'h00000001);
      axi_wr(`SWD_OFF_OPT2, 32'h00000000);
      axi_wr(`SWD_OFF_OPT, 32'h00000003);
      wait_rst(1200);
      check(n >= 256 * TDIV - 8 && n <= 256 * TDIV + 8, 1);
      repeat (3) @(posedge aclk);
      axi_rd(`SWD_OFF_ISTAT, rv);
      check(rv, 32'h00000001);
   endtask

   task automatic run_disable();
      axi_wr(`SWD_OFF_OPT2, 32'h00000001);
      axi_wr(`SWD_OFF_OPT, 32'h00000000);
      wait_rst(9000);
      check(n, 9000);
      axi_rd(`SWD_OFF_COUNT, rv);
      check(rv, 32'h0);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      s_axi_awaddr = '0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hF;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = '0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      debug_mode = 1'b0;
      stop_mode = 1'b0;
      fails = 0;
      compares = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      run_defaults();
      run_lock_timeout();
      run_khz();
      run_disable();
      summarize();
   end
endmodule // tb_top
